// ==== rtl/pixel_input_capture_deskew.sv ====
/*
 * pixel input capture with data de-skew, mode selection and an apb slave.
 * assumes pixel pins and straps are asynchronous to sys_clk_i and that the
 * pixel clock is well below a quarter of the system clock rate.
 */
// Notes on behaviour
// [R1] width select 0: 12 bits per edge
// [R2] 12-bit mode latches on both clock edges
// [R3] 24-bit: latch once, rising or falling per select
// [R4] edge select picks primary edge in 12-bit
// [R5] differential mode latches on phase crossover
// [R6] clock mode select meaning depends on width
// [R7] differential only in low-swing input mode
// [R8] high-swing mode forces single-ended clocking
// [R9] bus width alone fixes single or dual
// [R10] host config select picks register or straps
// [R11] 12-bit halves map to green, blue, red
// [R12] 24-bit word maps red, green, blue bytes
// [R13] deskew code or default sets latch offset
// [R14] offset is (code minus 4) steps
// [R15] deskew never shifts the forwarded clock
// [R16] deskew fields from straps or register
// [R17] controller holds sync steady while enabled
// [R18] halves assembled into one 24-bit pixel
`timescale 1ns/1ps
module pixel_input_capture_deskew (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // graphics controller pins
    input wire pixel_capture_pkg::video_pins_t video_pins_i,
    // straps
    input wire pixel_capture_pkg::mode_cfg_t strap_cfg_i,
    input wire logic low_swing_mode_i,
    input wire logic host_config_select_i,
    // apb slave
    input wire pixel_capture_pkg::apb_req_t apb_req_i,
    output pixel_capture_pkg::apb_rsp_t apb_rsp_o,
    // pixel stream toward the encoder
    output pixel_capture_pkg::pixel_t pixel_o,
    output logic pixel_valid_o,
    input wire logic pixel_ready_i,
    // forwarded pixel clock level
    output logic input_pixel_clock_o
);
    import pixel_capture_pkg::*;

    typedef enum logic {
        HALF_FIRST,
        HALF_SECOND
    } half_t;

    typedef struct packed {
        video_pins_t pin_meta;
        video_pins_t pin_sync;
        mode_cfg_t strap_meta;
        mode_cfg_t strap_sync;
        logic swing_meta;
        logic swing_sync;
        logic hcs_meta;
        logic hcs_sync;
        logic ref_lvl;
        logic [EDGE_DELAY_CYC-1:0] rise_pipe;
        logic [EDGE_DELAY_CYC-1:0] fall_pipe;
        logic [HIST_DEPTH-1:0][$bits(video_word_t)-1:0] hist;
        mode_cfg_t host_cfg;
        half_t phase;
        logic [11:0] first_half;
        video_word_t first_ctrl;
        pixel_t pix;
        logic pix_valid;
        logic overflow;
        logic [31:0] prdata;
        logic pslverr;
    } st_t;

    st_t s_r;
    st_t s_nxt;

    mode_cfg_t cfg;
    logic diff_mode;
    logic rise_now;
    logic fall_now;
    logic rise_d;
    logic fall_d;
    logic primary;
    logic secondary;
    logic [2:0] code;
    int unsigned tap;
    video_word_t sample;
    logic fifo_in_ready;
    logic [$clog2(FIFO_DEPTH):0] fifo_level;
    logic access;
    logic setup;
    logic [31:0] rd_val;
    logic mapped;

    always_comb begin
        s_nxt = s_r;

        // two-stage synchronisers
        s_nxt.pin_meta = video_pins_i;
        s_nxt.pin_sync = s_r.pin_meta;
        s_nxt.strap_meta = strap_cfg_i;
        s_nxt.strap_sync = s_r.strap_meta;
        s_nxt.swing_meta = low_swing_mode_i;
        s_nxt.swing_sync = s_r.swing_meta;
        s_nxt.hcs_meta = host_config_select_i;
        s_nxt.hcs_sync = s_r.hcs_meta;

        // [R10] [R16] config source select
        cfg = s_r.hcs_sync ? s_r.host_cfg : s_r.strap_sync;

        // [R6] [R7] [R8] differential only in low swing
        diff_mode = s_r.swing_sync && (cfg.bus_width_select ? cfg.clock_mode_select : !cfg.clock_mode_select);

        // [R5] crossover tracking; equal phases hold the level
        if (diff_mode) begin
            if (s_r.pin_sync.clk_pos && !s_r.pin_sync.clk_neg) begin
                s_nxt.ref_lvl = 1'b1;
            end else if (!s_r.pin_sync.clk_pos && s_r.pin_sync.clk_neg) begin
                s_nxt.ref_lvl = 1'b0;
            end
        end else begin
            s_nxt.ref_lvl = s_r.pin_sync.clk_pos;
        end
        rise_now = s_nxt.ref_lvl && !s_r.ref_lvl;
        fall_now = !s_nxt.ref_lvl && s_r.ref_lvl;

        // edges wait the bias so data after them can be taken
        s_nxt.rise_pipe = {s_r.rise_pipe[EDGE_DELAY_CYC-2:0], rise_now};
        s_nxt.fall_pipe = {s_r.fall_pipe[EDGE_DELAY_CYC-2:0], fall_now};
        rise_d = s_r.rise_pipe[EDGE_DELAY_CYC-1];
        fall_d = s_r.fall_pipe[EDGE_DELAY_CYC-1];

        // data history, newest in entry 0
        s_nxt.hist = {s_r.hist[HIST_DEPTH-2:0], s_r.pin_sync.word};

        // [R13] code or default offset
        code = cfg.deskew_enable ? cfg.deskew_step_code : DESKEW_DEFAULT_CODE;
        // [R14] tap for offset (code - 4) steps
        tap = (unsigned'(DESKEW_CODES) - unsigned'(int'(code))) * unsigned'(DESKEW_STEP_CYC) - 1;
        sample = video_word_t'(s_r.hist[tap]);

        // [R3] [R4] primary edge from edge select
        primary = cfg.edge_select ? rise_d : fall_d;
        secondary = cfg.edge_select ? fall_d : rise_d;

        s_nxt.pix_valid = 1'b0;
        // [R1] [R9] width alone picks single or dual edge
        if (cfg.bus_width_select) begin
            s_nxt.phase = HALF_FIRST;
            if (primary) begin
                // [R12] 24-bit byte mapping
                s_nxt.pix.red = sample.data[23:16];
                s_nxt.pix.green = sample.data[15:8];
                s_nxt.pix.blue = sample.data[7:0];
                s_nxt.pix.de = sample.de;
                s_nxt.pix.hsync = sample.hsync;
                s_nxt.pix.vsync = sample.vsync;
                s_nxt.pix.blanking_control_inputs = sample.blanking_control_inputs;
                s_nxt.pix_valid = 1'b1;
            end
        end else begin
            // [R2] both edges latch a half-pixel
            unique case (s_r.phase)
                HALF_FIRST: begin
                    if (primary) begin
                        s_nxt.first_half = sample.data[11:0];
                        s_nxt.first_ctrl = sample;
                        s_nxt.phase = HALF_SECOND;
                    end
                end
                HALF_SECOND: begin
                    if (secondary) begin
                        // [R11] half-pixel mapping
                        s_nxt.pix.green = {sample.data[3:0], s_r.first_half[11:8]};
                        s_nxt.pix.blue = s_r.first_half[7:0];
                        s_nxt.pix.red = sample.data[11:4];
                        // [R18] control from same pixel period
                        s_nxt.pix.de = s_r.first_ctrl.de;
                        s_nxt.pix.hsync = s_r.first_ctrl.hsync;
                        s_nxt.pix.vsync = s_r.first_ctrl.vsync;
                        s_nxt.pix.blanking_control_inputs = s_r.first_ctrl.blanking_control_inputs;
                        s_nxt.pix_valid = 1'b1;
                        s_nxt.phase = HALF_FIRST;
                    end else if (primary) begin
                        // a lost edge restarts on this half
                        s_nxt.first_half = sample.data[11:0];
                        s_nxt.first_ctrl = sample;
                    end
                end
            endcase
        end

        // apb slave: zero wait, read data caught in setup
        setup = apb_req_i.psel && !apb_req_i.penable;
        access = apb_req_i.psel && apb_req_i.penable;
        mapped = (apb_req_i.paddr == ADDR_CTRL) || (apb_req_i.paddr == ADDR_STATUS);
        rd_val = '0;
        if (apb_req_i.paddr == ADDR_CTRL) begin
            rd_val[CTRL_BUS_WIDTH_BIT] = s_r.host_cfg.bus_width_select;
            rd_val[CTRL_EDGE_BIT] = s_r.host_cfg.edge_select;
            rd_val[CTRL_CLK_MODE_BIT] = s_r.host_cfg.clock_mode_select;
            rd_val[CTRL_DESKEW_EN_BIT] = s_r.host_cfg.deskew_enable;
            rd_val[CTRL_DESKEW_CODE_LSB +: 3] = s_r.host_cfg.deskew_step_code;
        end else if (apb_req_i.paddr == ADDR_STATUS) begin
            rd_val[STAT_BUS_WIDTH_BIT] = cfg.bus_width_select;
            rd_val[STAT_EDGE_BIT] = cfg.edge_select;
            rd_val[STAT_DIFF_BIT] = diff_mode;
            rd_val[STAT_DESKEW_EN_BIT] = cfg.deskew_enable;
            // effective code: a disabled deskew shows the default
            rd_val[STAT_DESKEW_CODE_LSB +: 3] = code;
            rd_val[STAT_HOST_CFG_BIT] = s_r.hcs_sync;
            rd_val[STAT_OVERFLOW_BIT] = s_r.overflow;
            rd_val[STAT_LOW_SWING_BIT] = s_r.swing_sync;
            rd_val[STAT_LEVEL_LSB +: $bits(fifo_level)] = fifo_level;
        end
        if (setup) begin
            s_nxt.prdata = apb_req_i.pwrite ? 32'h0000_0000 : rd_val;
            s_nxt.pslverr = !mapped;
        end

        if (access && apb_req_i.pwrite && apb_req_i.paddr == ADDR_CTRL) begin
            s_nxt.host_cfg.bus_width_select = apb_req_i.pwdata[CTRL_BUS_WIDTH_BIT];
            s_nxt.host_cfg.edge_select = apb_req_i.pwdata[CTRL_EDGE_BIT];
            s_nxt.host_cfg.clock_mode_select = apb_req_i.pwdata[CTRL_CLK_MODE_BIT];
            s_nxt.host_cfg.deskew_enable = apb_req_i.pwdata[CTRL_DESKEW_EN_BIT];
            s_nxt.host_cfg.deskew_step_code = apb_req_i.pwdata[CTRL_DESKEW_CODE_LSB +: 3];
        end
        // write one clears; a new loss in the same cycle wins
        if (access && apb_req_i.pwrite && apb_req_i.paddr == ADDR_STATUS &&
            apb_req_i.pwdata[STAT_OVERFLOW_BIT]) begin
            s_nxt.overflow = 1'b0;
        end
        // the pixel clock cannot be stalled, so a full buffer drops
        if (s_r.pix_valid && !fifo_in_ready) begin
            s_nxt.overflow = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '0;
            s_r.host_cfg <= CFG_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    pixel_fifo #(
        .WIDTH($bits(pixel_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .in_data_i(s_r.pix),
        .in_valid_i(s_r.pix_valid),
        .in_ready_o(fifo_in_ready),
        .out_data_o(pixel_o),
        .out_valid_o(pixel_valid_o),
        .out_ready_i(pixel_ready_i),
        .level_o(fifo_level)
    );

    assign apb_rsp_o.prdata = s_r.prdata;
    assign apb_rsp_o.pready = apb_req_i.psel && apb_req_i.penable;
    assign apb_rsp_o.pslverr = s_r.pslverr && apb_req_i.psel && apb_req_i.penable;

    // [R15] clock level passes without deskew delay
    assign input_pixel_clock_o = s_r.ref_lvl;
endmodule

// ==== common/pixel_capture_pkg.sv ====
/*
 * shared constants and types for the pixel input capture stage.
 * assumes a 40 MHz system clock and an apb register bus with 32-bit data.
 */
package pixel_capture_pkg;

    // timing
    localparam int SYS_CLK_PERIOD_PS = 25000;
    localparam int DESKEW_STEP_PS = 25000;
    localparam int DESKEW_STEP_CYC = (DESKEW_STEP_PS / SYS_CLK_PERIOD_PS) < 1 ? 1 :
                                     (DESKEW_STEP_PS / SYS_CLK_PERIOD_PS);
    localparam int DESKEW_BIAS = 4;
    localparam int DESKEW_CODES = 8;
    localparam int EDGE_DELAY_CYC = DESKEW_BIAS * DESKEW_STEP_CYC;
    localparam int HIST_DEPTH = DESKEW_CODES * DESKEW_STEP_CYC;
    localparam logic [2:0] DESKEW_DEFAULT_CODE = 3'h4;

    // buffering
    localparam int FIFO_DEPTH = 32;

    // apb map
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
    localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h004;

    // control register fields
    localparam int CTRL_BUS_WIDTH_BIT = 0;
    localparam int CTRL_EDGE_BIT = 1;
    localparam int CTRL_CLK_MODE_BIT = 2;
    localparam int CTRL_DESKEW_EN_BIT = 3;
    localparam int CTRL_DESKEW_CODE_LSB = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0040;

    // status register fields
    localparam int STAT_BUS_WIDTH_BIT = 0;
    localparam int STAT_EDGE_BIT = 1;
    localparam int STAT_DIFF_BIT = 2;
    localparam int STAT_DESKEW_EN_BIT = 3;
    localparam int STAT_DESKEW_CODE_LSB = 4;
    localparam int STAT_HOST_CFG_BIT = 7;
    localparam int STAT_OVERFLOW_BIT = 8;
    localparam int STAT_LOW_SWING_BIT = 9;
    localparam int STAT_LEVEL_LSB = 16;

    typedef struct packed {
        logic bus_width_select;
        logic edge_select;
        logic clock_mode_select;
        logic deskew_enable;
        logic [2:0] deskew_step_code;
    } mode_cfg_t;

    localparam mode_cfg_t CFG_RESET = '{
        bus_width_select: CTRL_RESET[CTRL_BUS_WIDTH_BIT],
        edge_select: CTRL_RESET[CTRL_EDGE_BIT],
        clock_mode_select: CTRL_RESET[CTRL_CLK_MODE_BIT],
        deskew_enable: CTRL_RESET[CTRL_DESKEW_EN_BIT],
        deskew_step_code: CTRL_RESET[CTRL_DESKEW_CODE_LSB +: 3]
    };

    typedef struct packed {
        logic [23:0] data;
        logic de;
        logic hsync;
        logic vsync;
        logic [1:0] blanking_control_inputs;
    } video_word_t;

    typedef struct packed {
        logic clk_pos;
        logic clk_neg;
        video_word_t word;
    } video_pins_t;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic de;
        logic hsync;
        logic vsync;
        logic [1:0] blanking_control_inputs;
    } pixel_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_AW-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

endpackage

// ==== rtl/pixel_fifo.sv ====
/*
 * pixel fifo: DEPTH words of storage plus a registered output word.
 * assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module pixel_fifo #(
    parameter int WIDTH = 29,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // fill side
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // drain side
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    // fill level
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
        logic [WIDTH-1:0] dout;
        logic dvalid;
    } fifo_st_t;

    fifo_st_t s_r;
    fifo_st_t s_nxt;
    logic push;
    logic pop;

    always_comb begin
        s_nxt = s_r;
        push = in_valid_i && (s_r.count != (AW+1)'(DEPTH));
        pop = (s_r.count != '0) && (!s_r.dvalid || out_ready_i);
        if (pop) begin
            s_nxt.dout = s_r.mem[s_r.rptr];
            s_nxt.dvalid = 1'b1;
            s_nxt.rptr = s_r.rptr + AW'(1);
        end else if (out_ready_i) begin
            s_nxt.dvalid = 1'b0;
        end
        if (push) begin
            s_nxt.mem[s_r.wptr] = in_data_i;
            s_nxt.wptr = s_r.wptr + AW'(1);
        end
        s_nxt.count = s_r.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // full is storage full; the output word is extra slack
    assign in_ready_o = (s_r.count != (AW+1)'(DEPTH));
    assign out_data_o = s_r.dout;
    assign out_valid_o = s_r.dvalid;
    assign level_o = s_r.count;
endmodule

// ==== verif/pixel_capture_asserts.sv ====
/*
 * port checks for the pixel capture stage.
 * assumes a bind to the top module; sees only its ports.
 */
`timescale 1ns/1ps
module pixel_capture_asserts (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // watched ports
    input wire pixel_capture_pkg::video_pins_t video_pins_i,
    input wire pixel_capture_pkg::apb_req_t apb_req_i,
    input wire pixel_capture_pkg::apb_rsp_t apb_rsp_o,
    input wire pixel_capture_pkg::pixel_t pixel_o,
    input wire logic pixel_valid_o,
    input wire logic pixel_ready_i,
    input wire logic input_pixel_clock_o
);
    import pixel_capture_pkg::*;
    logic acc;
    logic rd_ctl;
    logic rd_st;
    logic [1:0] pins_q;
    logic [3:0] since_r;
    assign acc = apb_req_i.psel && apb_req_i.penable;
    assign rd_ctl = acc && !apb_req_i.pwrite && apb_req_i.paddr == ADDR_CTRL;
    assign rd_st = acc && !apb_req_i.pwrite && apb_req_i.paddr == ADDR_STATUS;
    // pin age; slack covers the two-flop sync
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pins_q <= 2'h0;
            since_r <= 4'h0;
        end else begin
            pins_q <= {video_pins_i.clk_pos, video_pins_i.clk_neg};
            if (pins_q != {video_pins_i.clk_pos, video_pins_i.clk_neg}) begin
                since_r <= 4'h0;
            end else if (since_r != 4'hf) begin
                since_r <= since_r + 4'h1;
            end
        end
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    AST_APB_READY: assert property (acc |-> apb_rsp_o.pready) else $error("pready low in access");
    AST_APB_IDLE: assert property (!acc |-> !apb_rsp_o.pready) else $error("pready outside access");
    AST_UNMAPPED: assert property (acc && apb_req_i.paddr != ADDR_CTRL && apb_req_i.paddr != ADDR_STATUS
        |-> apb_rsp_o.pslverr && apb_rsp_o.prdata == 32'h0) else $error("unmapped access not refused");
    AST_MAPPED: assert property (rd_ctl || rd_st |-> !apb_rsp_o.pslverr) else $error("mapped read refused");
    AST_CTRL_RSVD: assert property (rd_ctl |-> apb_rsp_o.prdata[31:7] == 25'h0) else $error("ctrl upper bits set");
    AST_HS_SINGLE: assert property (rd_st && !apb_rsp_o.prdata[STAT_LOW_SWING_BIT]
        |-> !apb_rsp_o.prdata[STAT_DIFF_BIT]) else $error("differential in high swing");
    AST_CODE_DEFAULT: assert property (rd_st && !apb_rsp_o.prdata[STAT_DESKEW_EN_BIT]
        |-> apb_rsp_o.prdata[STAT_DESKEW_CODE_LSB +: 3] == DESKEW_DEFAULT_CODE) else $error("default code wrong");
    AST_VALID_HOLD: assert property (pixel_valid_o && !pixel_ready_i
        |=> pixel_valid_o && $stable(pixel_o)) else $error("pixel dropped while stalled");
    AST_CLOCK_FOLLOW: assert property ($changed(input_pixel_clock_o) |-> since_r <= 4'h4)
        else $error("clock out moved without pin edge");
    AST_CLK_RISE: assert property ($rose(video_pins_i.clk_pos) && !video_pins_i.clk_neg
        |-> ##[1:4] input_pixel_clock_o) else $error("clock out missed rise");
    cover property (rd_st);
    cover property (pixel_valid_o && pixel_ready_i);
    cover property (pixel_valid_o && !pixel_ready_i);
endmodule

// ==== verif/gfx_source_model.sv ====
/*
 * graphics controller model driving pixel clock and data.
 * assumes the bench calls its tasks; clock idles between frames.
 */
`timescale 1ns/1ps
module gfx_source_model (
    // pins toward the capture stage
    output pixel_capture_pkg::video_pins_t pins_o
);
    import pixel_capture_pkg::*;
    logic rise_r = 1'b1;
    logic diff_r = 1'b0;
    initial pins_o = '0;
    // idle level sits before the primary edge
    task automatic idle(input logic rise, input logic diff);
        rise_r = rise;
        diff_r = diff;
        clk_set(!rise);
    endtask
    task automatic clk_set(input logic v);
        pins_o.clk_pos = v;
        // single-ended: minus phase tied low
        pins_o.clk_neg = diff_r & !v;
    endtask
    task automatic send(input video_word_t w1, input logic [23:0] d2);
        pins_o.word = w1;
        #50;
        clk_set(rise_r);
        #50;
        pins_o.word.data = d2;
        #50;
        clk_set(!rise_r);
        #50;
    endtask
    // released lines show the inverse, never stale data
    task automatic stop();
        pins_o.word = ~pins_o.word;
    endtask
endmodule

// ==== verif/tb_top.sv ====
/*
 * testbench for the pixel capture stage: apb tasks and pixel scenarios.
 * assumes the checker and the controller model in the same folder.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        num_checks++; \
        if ((g) !== (e)) begin \
            n_fail++; \
            $display("[FAIL] %s exp %h got %h", nm, e, g); \
        end \
    end
module tb_top;
    import pixel_capture_pkg::*;
    localparam logic [15:0] MODES = 16'h0ad3;
    logic sys_clk;
    logic reset_n;
    logic low_swing;
    logic host_cfg;
    logic ready;
    logic pix_valid;
    logic clk_out;
    logic rerr;
    logic [31:0] rdat;
    mode_cfg_t straps;
    video_pins_t pins;
    apb_req_t req;
    apb_rsp_t rsp;
    pixel_t pix;
    pixel_t got[$];
    pixel_t exp_q[$];
    int n_fail;
    int num_checks;
    pixel_input_capture_deskew u_pixel_input_capture_deskew (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n), .video_pins_i(pins), .strap_cfg_i(straps),
        .low_swing_mode_i(low_swing), .host_config_select_i(host_cfg), .apb_req_i(req), .apb_rsp_o(rsp),
        .pixel_o(pix), .pixel_valid_o(pix_valid), .pixel_ready_i(ready), .input_pixel_clock_o(clk_out)
    );
    gfx_source_model u_gfx_source_model (.pins_o(pins));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (pix_valid === 1'b1 && ready === 1'b1) begin
            got.push_back(pix);
        end
    end
    task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (rsp.pready !== 1'b1);
        rdat = rsp.prdata;
        rerr = rsp.pslverr;
        req <= '0;
        @(posedge sys_clk);
    endtask
    // m is {low swing, clock mode, edge, width}; dk is {deskew enable, code}
    task automatic px(input logic [3:0] m, input int n, input logic rdy, input logic [3:0] dk);
        video_word_t w;
        logic [23:0] d2;
        logic late;
        // second data word lands two steps after the primary edge
        late = dk[3] && (dk[2:0] > 3'h5);
        apb(1'b1, ADDR_CTRL, {25'h0, dk[2:0], dk[3], m[2:0]});
        low_swing <= m[3];
        ready <= 1'b1;
        #7;
        u_gfx_source_model.idle(m[1], m[3] & (m[0] ? m[2] : !m[2]));
        repeat (20) @(posedge sys_clk);
        got.delete();
        exp_q.delete();
        ready <= rdy;
        #7;
        for (int i = 0; i < n; i++) begin
            w = {24'(24'h3c5a96 + 24'h0102f3 * i), 5'h15};
            d2 = {w.data[11:0], w.data[23:12]};
            exp_q.push_back(m[0] ? pixel_t'(late ? {d2, w[4:0]} : w) : {d2[11:0], w.data[11:0], w[4:0]});
            u_gfx_source_model.send(w, d2);
        end
        u_gfx_source_model.stop();
        repeat (30) @(posedge sys_clk);
    endtask
    task automatic cmp(input int n);
        `CHK("count", n, got.size())
        for (int i = 0; i < n && i < got.size(); i++) begin
            `CHK("pixel", exp_q[i], got[i])
        end
    endtask
    task automatic finish_test();
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        finish_test();
    end
    initial begin
        reset_n = 1'b0;
        low_swing = 1'b0;
        host_cfg = 1'b1;
        ready = 1'b1;
        straps = '0;
        req = '0;
        n_fail = 0;
        num_checks = 0;
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        `CHK("ctrl_reset", CTRL_RESET, rdat)
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("status_reset", 32'h0000_00c0, rdat)
        apb(1'b0, 12'h008, 32'h0);
        `CHK("slverr", 1'b1, rerr)
        $display("test registers done");
        for (int m = 0; m < 8; m++) begin
            low_swing <= m[2];
            apb(1'b1, ADDR_CTRL, {29'h0, m[1], 1'b0, m[0]});
            repeat (4) @(posedge sys_clk);
            apb(1'b0, ADDR_STATUS, 32'h0);
            `CHK("diff", m[2] & (m[0] ? m[1] : !m[1]), rdat[STAT_DIFF_BIT])
            `CHK("width", m[0], rdat[STAT_BUS_WIDTH_BIT])
        end
        $display("test clock modes done");
        host_cfg <= 1'b0;
        low_swing <= 1'b0;
        straps <= 7'b1101110;
        repeat (6) @(posedge sys_clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("strap_status", 10'h06b, rdat[9:0])
        straps <= 7'b1100110;
        repeat (6) @(posedge sys_clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("strap_default", 10'h043, rdat[9:0])
        host_cfg <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h7f);
        apb(1'b0, ADDR_CTRL, 32'h0);
        `CHK("ctrl_rw", 32'h7f, rdat)
        $display("test config source done");
        for (int k = 0; k < 4; k++) begin
            px(MODES[4*k +: 4], 3, 1'b1, 4'h4);
            cmp(3);
        end
        $display("test capture done");
        // code 7 samples three steps after the edge
        px(4'h3, 3, 1'b1, 4'hf);
        cmp(3);
        $display("test deskew done");
        px(4'h3, 35, 1'b0, 4'h4);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("overflow", 1'b1, rdat[STAT_OVERFLOW_BIT])
        ready <= 1'b1;
        repeat (80) @(posedge sys_clk);
        cmp(33);
        apb(1'b1, ADDR_STATUS, 32'h100);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("ovf_clear", 1'b0, rdat[STAT_OVERFLOW_BIT])
        `CHK("level", 6'h0, rdat[STAT_LEVEL_LSB +: 6])
        $display("test buffer done");
        finish_test();
    end
endmodule
bind pixel_input_capture_deskew pixel_capture_asserts u_pixel_capture_asserts (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .video_pins_i(video_pins_i), .apb_req_i(apb_req_i),
    .apb_rsp_o(apb_rsp_o), .pixel_o(pixel_o), .pixel_valid_o(pixel_valid_o), .pixel_ready_i(pixel_ready_i),
    .input_pixel_clock_o(input_pixel_clock_o)
);
